// >>> hdl/itp_pkg.sv
// package: constants, carriers and helpers of the isochronous transmit pacing block
package itp_pkg;

  // ==========================================================
  // bus cycle numbering
  localparam int unsigned ITP_CYCLES_PER_SEC = 8000;
  localparam int unsigned ITP_CYC_W = 13;
  localparam logic [12:0] ITP_CYC_LAST = 13'h1_F3F;
  localparam int unsigned ITP_WORKAHEAD_GOAL = 2;
  localparam logic [1:0] ITP_PRIME_TOKENS = 2'h2;
  localparam logic [1:0] ITP_ROLLS_FOR_LOSS = 2'h2;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ITP_OFS_CTRL = 8'h00;
  localparam logic [7:0] ITP_OFS_STATUS = 8'h04;
  localparam logic [7:0] ITP_OFS_START_CYCLE = 8'h08;
  localparam logic [7:0] ITP_OFS_CYCLE_DEP = 8'h0C;
  localparam logic [7:0] ITP_OFS_STOPPED = 8'h10;
  localparam logic [7:0] ITP_OFS_LOSS_COUNT = 8'h14;
  localparam int unsigned ITP_CTRL_ENABLE_BIT = 0;
  localparam int unsigned ITP_ST_AHEAD_LSB = 0;
  localparam int unsigned ITP_ST_LOST_LSB = 8;
  localparam int unsigned ITP_ST_EXPCYC_LSB = 16;
  localparam logic [31:0] ITP_RESET_WORD = 32'h0000_0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic token;
    logic last;
    logic [31:0] data;
  } itp_fifo_word_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } itp_tx_word_t;

  typedef enum logic [2:0] {
    ITP_WAIT, ITP_CHECK, ITP_ISO, ITP_ARB, ITP_SEND, ITP_DRAIN, ITP_POSTUF
  } itp_link_state_t;

  // ==========================================================
  // helpers
  function automatic logic [12:0] itp_cyc_add(input logic [12:0] c, input logic [7:0] d);
    logic signed [14:0] s;
    s = $signed({2'b00, c}) + $signed({{7{d[7]}}, d});
    if (s < 0) begin
      s = s + 15'sd8000;
    end else if (s >= 15'sd8000) begin
      s = s - 15'sd8000;
    end
    return s[12:0];
  endfunction : itp_cyc_add

  function automatic logic [12:0] itp_cyc_inc(input logic [12:0] c);
    return (c == ITP_CYC_LAST) ? 13'h0_000 : 13'(c + 13'h0_001);
  endfunction : itp_cyc_inc

endpackage : itp_pkg

// >>> hdl/itp_pace_counters.sv
// module: workahead and pending-skip counters with start-match cycle value
`timescale 1ns/1ps
module itp_pace_counters #(
  parameter int AW = 4,
  parameter int LW = 4,
  parameter logic signed [AW-1:0] AHEAD_MAX = 4'sh7,
  parameter logic signed [AW-1:0] AHEAD_MIN = -4'sh8,
  parameter logic [LW-1:0] LOST_MAX = 4'hF,
  parameter logic [LW-1:0] LOST_MIN = 4'h0
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // events
  input wire logic passDone,
  input wire logic cycleSync,
  input wire logic lostPulse,
  input wire logic passSkipped,
  input wire logic [12:0] cycleNumber,
  // results
  output logic signed [AW-1:0] ahead,
  output logic [LW-1:0] lost,
  output logic [12:0] matchCycle
);
  import itp_pkg::*;

  logic signed [AW-1:0] ahead_q;
  logic [LW-1:0] lost_q;

  // ==========================================================
  // saturating counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ahead_q <= '0;
    end else if (passDone && !cycleSync && ahead_q != AHEAD_MAX) begin
      ahead_q <= ahead_q + AW'(1);
    end else if (!passDone && cycleSync && ahead_q != AHEAD_MIN) begin
      ahead_q <= ahead_q - AW'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lost_q <= '0;
    end else if (!passSkipped && lostPulse && lost_q != LOST_MAX) begin
      lost_q <= lost_q + 1'b1;
    end else if (passSkipped && !lostPulse && lost_q != LOST_MIN) begin
      lost_q <= lost_q - 1'b1;
    end
  end

  assign ahead = ahead_q;
  assign lost = lost_q;
  // signed sum wraps modulo the cycles of one second
  assign matchCycle = itp_cyc_add(cycleNumber, 8'($signed(ahead_q)));

  ahead_sat_a: assert property (@(posedge clock) disable iff (!arst_n)
    (ahead_q == AHEAD_MAX && passDone && !cycleSync) |=> ahead_q == AHEAD_MAX)
    else $error("workahead passed its upper bound");
  lost_up_a: assert property (@(posedge clock) disable iff (!arst_n)
    (lostPulse && !passSkipped && lost_q != LOST_MAX) |=> lost_q == $past(lost_q) + 1'b1)
    else $error("pending skips did not count a loss");
  ahead_down_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cycleSync && !passDone && ahead_q != AHEAD_MIN) |=> ahead_q == $past(ahead_q) - AW'(1))
    else $error("workahead did not count a cycle start");

endmodule : itp_pace_counters

// >>> hdl/itp_iso_tx_pacing.sv
// module: isochronous transmit cycle pacing, link sequencer, DMA pacing, AHB-Lite registers
//
// How it works
// - one cycle of packets per transmit entry
// - loss mid-loop signals DMA, returns waiting
// - entry token: pop, advance expected cycle
// - not isochronous before packet: signal loss
// - arbitrate until won; two rollovers mean loss
// - won with empty FIFO means loss
// - underflow eats packet rest; loss unless token
// - underflow on cycle's last packet: no loss
// - after packet: token ends cycle, else continue
// - underflow then bus lost: loss, defer packet
// - workahead counter saturating up/down on events
// - pending-skip counter saturating up/down on events
// - match cycle = link cycle + workahead mod 8000
// - skipped pass = done while skipping
// - startup writes two end-of-cycle tokens
// - service when behind or skips pending; stall
// - loss pulse single-cycle; cycle number balanced
// - skip until none pending, then refill
// - mismatch stops only cycle-dependent contexts
// - waiting: two rollovers without start mean loss
// - skipped cycle writes no end-of-cycle token
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module itp_iso_tx_pacing #(
  parameter int NCTX = 8,
  parameter int AW = 4,
  parameter int LW = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // link events
  input wire logic cycleStart,
  input wire logic [12:0] cycleNumber,
  input wire logic cycleRollover,
  input wire logic isoPeriod,
  input wire logic arbWon,
  output logic arbReq,
  // transmit FIFO read side
  input wire logic fifoValid,
  input wire itp_pkg::itp_fifo_word_t fifoHead,
  output logic fifoPop,
  // packet stream to the PHY
  output itp_pkg::itp_tx_word_t txWord,
  // DMA context walker
  input wire logic contextPassDone,
  input wire logic skipActive,
  input wire logic fifoWrReady,
  output logic serviceReq,
  output logic skipNow,
  output logic eocWrite,
  output logic [12:0] matchCycle,
  output logic startMatch,
  // cycle number consistency
  input wire logic cycleNumberMismatch,
  output logic [NCTX-1:0] contextStop
);
  import itp_pkg::*;

  // ==========================================================
  // registers over AHB-Lite
  logic enable_q;
  logic [12:0] startCycle_q;
  logic [NCTX-1:0] cycleDep_q;
  logic [NCTX-1:0] stopped_q;
  logic [15:0] lossCount_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdata_q;
  logic addrPhase;
  logic signed [AW-1:0] ahead;
  logic [LW-1:0] lost;
  itp_link_state_t state_q;
  logic [12:0] expCycle_q;
  logic linkLost;

  assign addrPhase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = ITP_RESET_WORD;
    case (a)
      ITP_OFS_CTRL: v[ITP_CTRL_ENABLE_BIT] = enable_q;
      ITP_OFS_STATUS: begin
        v[ITP_ST_AHEAD_LSB +: AW] = ahead;
        v[ITP_ST_LOST_LSB +: LW] = lost;
        v[ITP_ST_EXPCYC_LSB +: 13] = expCycle_q;
        v[31:29] = state_q;
      end
      ITP_OFS_START_CYCLE: v[12:0] = startCycle_q;
      ITP_OFS_CYCLE_DEP: v[NCTX-1:0] = cycleDep_q;
      ITP_OFS_STOPPED: v[NCTX-1:0] = stopped_q;
      ITP_OFS_LOSS_COUNT: v[15:0] = lossCount_q;
      default: v = ITP_RESET_WORD;
    endcase
    return v;
  endfunction : reg_read

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      rdata_q <= ITP_RESET_WORD;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr[7:0];
      end
      // read data is fetched during the address phase for zero wait states
      rdata_q <= (addrPhase && !hwrite) ? reg_read(haddr[7:0]) : ITP_RESET_WORD;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= 1'b0;
      startCycle_q <= '0;
      cycleDep_q <= '0;
    end else if (wrPend_q) begin
      case (wrAddr_q)
        ITP_OFS_CTRL: enable_q <= hwdata[ITP_CTRL_ENABLE_BIT];
        ITP_OFS_START_CYCLE: startCycle_q <= hwdata[12:0];
        ITP_OFS_CYCLE_DEP: cycleDep_q <= hwdata[NCTX-1:0];
        default: ;
      endcase
    end
  end

  // stop flags: mismatch sets, write-one clears, set wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stopped_q <= '0;
    end else begin
      stopped_q <= (stopped_q & ~((wrPend_q && wrAddr_q == ITP_OFS_STOPPED) ?
                    hwdata[NCTX-1:0] : '0)) |
                   (cycleNumberMismatch ? cycleDep_q : '0);
    end
  end
  assign contextStop = stopped_q;

  // ==========================================================
  // link-side sequencer
  logic [1:0] rollCnt_q;
  logic afterPkt_q;
  logic underflow_q;
  logic enterWait;
  itp_tx_word_t txWord_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rollCnt_q <= '0;
    end else if (!enable_q || cycleStart || linkLost || (state_q == ITP_ISO)) begin
      rollCnt_q <= '0;
    end else if (cycleRollover && rollCnt_q != ITP_ROLLS_FOR_LOSS) begin
      rollCnt_q <= rollCnt_q + 2'h1;
    end
  end

  always_comb begin
    linkLost = 1'b0;
    case (state_q)
      ITP_WAIT: linkLost = enable_q && rollCnt_q == ITP_ROLLS_FOR_LOSS;
      ITP_CHECK: linkLost = fifoValid && !fifoHead.token && afterPkt_q &&
                            underflow_q && !arbWon;
      ITP_ISO: linkLost = !isoPeriod;
      ITP_ARB: linkLost = !isoPeriod || rollCnt_q == ITP_ROLLS_FOR_LOSS ||
                          (arbWon && !fifoValid);
      ITP_POSTUF: linkLost = fifoValid && !fifoHead.token;
      default: linkLost = 1'b0;
    endcase
  end

  always_comb begin
    fifoPop = 1'b0;
    case (state_q)
      ITP_CHECK: fifoPop = fifoValid && fifoHead.token;
      ITP_SEND, ITP_DRAIN: fifoPop = fifoValid;
      default: fifoPop = 1'b0;
    endcase
  end

  assign arbReq = (state_q == ITP_ARB) || (state_q == ITP_SEND);
  assign enterWait = linkLost || (state_q == ITP_CHECK && fifoValid && fifoHead.token);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ITP_WAIT;
      afterPkt_q <= 1'b0;
      underflow_q <= 1'b0;
    end else if (linkLost || !enable_q) begin
      state_q <= ITP_WAIT;
    end else begin
      case (state_q)
        ITP_WAIT: begin
          if (cycleStart && cycleNumber == expCycle_q) begin
            state_q <= ITP_CHECK;
            afterPkt_q <= 1'b0;
            underflow_q <= 1'b0;
          end
        end
        ITP_CHECK: begin
          if (fifoPop) begin
            state_q <= ITP_WAIT;
          end else if (fifoValid) begin
            state_q <= ITP_ISO;
          end
        end
        ITP_ISO: state_q <= ITP_ARB;
        ITP_ARB: begin
          if (arbWon) begin
            state_q <= ITP_SEND;
            underflow_q <= 1'b0;
          end
        end
        ITP_SEND: begin
          if (!fifoValid) begin
            underflow_q <= 1'b1;
            state_q <= ITP_DRAIN;
          end else if (fifoHead.last) begin
            state_q <= ITP_CHECK;
            afterPkt_q <= 1'b1;
          end
        end
        ITP_DRAIN: begin
          if (fifoValid && fifoHead.last) begin
            state_q <= ITP_POSTUF;
          end
        end
        ITP_POSTUF: begin
          if (fifoValid) begin
            state_q <= ITP_CHECK;
            afterPkt_q <= 1'b1;
          end
        end
        default: state_q <= ITP_WAIT;
      endcase
    end
  end

  // expected cycle: loaded on enable, advanced by tokens and waiting losses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      expCycle_q <= '0;
    end else if (!enable_q) begin
      expCycle_q <= itp_cyc_inc(cycleNumber);
    end else if ((state_q == ITP_CHECK && fifoPop) ||
                 (state_q == ITP_WAIT && linkLost)) begin
      expCycle_q <= itp_cyc_inc(expCycle_q);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txWord_q <= '0;
    end else begin
      txWord_q.valid <= state_q == ITP_SEND && fifoValid;
      txWord_q.last <= fifoHead.last;
      txWord_q.data <= fifoHead.data;
    end
  end
  assign txWord = txWord_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lossCount_q <= '0;
    end else if (linkLost && lossCount_q != 16'hF_FFF) begin
      lossCount_q <= lossCount_q + 16'h0_001;
    end
  end

  // ==========================================================
  // DMA-side pacing
  logic syncPulse_q;
  logic [12:0] syncCycle_q;
  logic lostPulse_q;
  logic [1:0] prime_q;
  logic enablePrev_q;
  logic stall_q;
  logic primeWrite;
  logic passSkipped;

  // cycle number and start pulse take the same single stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncPulse_q <= 1'b0;
      syncCycle_q <= '0;
      lostPulse_q <= 1'b0;
    end else begin
      syncPulse_q <= cycleStart && enable_q;
      syncCycle_q <= cycleNumber;
      lostPulse_q <= linkLost;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enablePrev_q <= 1'b0;
      prime_q <= '0;
    end else begin
      enablePrev_q <= enable_q;
      if (enable_q && !enablePrev_q) begin
        prime_q <= ITP_PRIME_TOKENS;
      end else if (primeWrite) begin
        prime_q <= prime_q - 2'h1;
      end
    end
  end

  assign primeWrite = prime_q != 2'h0 && fifoWrReady;
  assign passSkipped = contextPassDone && skipActive;
  assign eocWrite = primeWrite || (contextPassDone && !skipActive);

  // stall after a pass until the link reports start or loss
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stall_q <= 1'b0;
    end else if (syncPulse_q || lostPulse_q) begin
      stall_q <= 1'b0;
    end else if (contextPassDone) begin
      stall_q <= 1'b1;
    end
  end

  itp_pace_counters #(
    .AW(AW),
    .LW(LW)
  ) u_counters (
    .clock(clock),
    .arst_n(arst_n),
    .passDone(contextPassDone || primeWrite),
    .cycleSync(syncPulse_q),
    .lostPulse(lostPulse_q),
    .passSkipped(passSkipped),
    .cycleNumber(syncCycle_q),
    .ahead(ahead),
    .lost(lost),
    .matchCycle(matchCycle)
  );

  // a lost cycle bypasses the stall so skipping starts at once
  assign skipNow = lost != '0;
  assign serviceReq = enable_q && prime_q == 2'h0 && (!stall_q || skipNow) &&
                      (ahead < $signed(AW'(ITP_WORKAHEAD_GOAL)) || skipNow);
  assign startMatch = matchCycle == startCycle_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  loss_pulse_a: assert property (linkLost |=> !linkLost)
    else $error("loss indication longer than one cycle");
  token_entry_a: assert property (
    (enable_q && state_q == ITP_CHECK && fifoValid && fifoHead.token && !linkLost)
    |=> state_q == ITP_WAIT && expCycle_q == itp_cyc_inc($past(expCycle_q)))
    else $error("end-of-cycle token not consumed");
  iso_gone_a: assert property ((state_q == ITP_ISO && !isoPeriod) |-> linkLost)
    else $error("packet tried outside isochronous period");
  arb_empty_a: assert property ((state_q == ITP_ARB && arbWon && !fifoValid) |-> linkLost)
    else $error("empty FIFO at arbitration win not a loss");
  arb_rolls_a: assert property (
    (state_q == ITP_ARB && rollCnt_q == ITP_ROLLS_FOR_LOSS) |-> linkLost ##1 state_q == ITP_WAIT)
    else $error("double rollover in arbitration not a loss");
  last_uf_a: assert property ((state_q == ITP_POSTUF && fifoValid && fifoHead.token)
    |-> !linkLost ##1 (state_q == ITP_CHECK || !enable_q))
    else $error("underflow on last packet reported as loss");
  skip_token_a: assert property ((contextPassDone && skipActive && prime_q == 2'h0)
    |-> !eocWrite)
    else $error("token written for skipped cycle");
  service_gate_a: assert property (serviceReq |-> (ahead < 2 || lost != '0))
    else $error("service requested while two cycles ahead");
  loss_count_a: assert property (linkLost |=> lostPulse_q ##1 (skipNow || $past(lost) != '0 ||
    $past(contextPassDone)))
    else $error("loss did not reach the pending-skip counter");
  prime_a: assert property ((enable_q && !enablePrev_q) |=> prime_q == ITP_PRIME_TOKENS)
    else $error("startup token priming missing");

  send_cycle_c: cover property (state_q == ITP_CHECK && afterPkt_q && fifoPop);
  underflow_c: cover property (state_q == ITP_POSTUF && fifoValid && fifoHead.token);
  skip_c: cover property (passSkipped && skipNow);
  mismatch_c: cover property (cycleNumberMismatch && cycleDep_q != '0);

endmodule : itp_iso_tx_pacing

// >>> verif/itp_link_model.sv
// partner: transmit FIFO read side and PHY packet sink
`timescale 1ns/1ps
module itp_link_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // fifo read side
  input wire logic fifoPop,
  output logic fifoValid,
  output itp_pkg::itp_fifo_word_t fifoHead,
  // packet stream
  input wire itp_pkg::itp_tx_word_t txWord
);
  import itp_pkg::*;
  itp_fifo_word_t store[$];
  itp_tx_word_t sent[$];

  // ====
  // queue only; the head shows up at a rising edge, as from a real FIFO
  task automatic push(input logic tok, input logic lst, input logic [31:0] d);
    store.push_back({tok, lst, d});
  endtask : push

  // ====
  // an empty head toggles so a stale word never passes for data
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      store.delete();
      fifoValid <= 1'b0;
      fifoHead <= '0;
    end else begin
      if (fifoPop && store.size() != 0) begin
        void'(store.pop_front());
      end
      if (txWord.valid === 1'b1) begin
        sent.push_back(txWord);
      end
      fifoValid <= store.size() != 0;
      fifoHead <= (store.size() != 0) ? store[0] : ~fifoHead;
    end
  end
endmodule : itp_link_model

// >>> verif/itp_iso_tx_pacing_test.sv
// testbench: isochronous transmit pacing scenarios
`timescale 1ns/1ps
module itp_iso_tx_pacing_test;
  import itp_pkg::*;
  logic clock, arst_n, hsel, hwrite, cycleStart, cycleRollover, isoPeriod, arbWon;
  logic contextPassDone, skipActive, hreadyout, hresp, arbReq, fifoValid, fifoPop;
  logic serviceReq, skipNow, eocWrite, startMatch, cycleNumberMismatch;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [12:0] cycleNumber, matchCycle, expCyc, e1;
  logic [7:0] contextStop;
  itp_fifo_word_t fifoHead;
  itp_tx_word_t txWord;
  int nErrors = 0;
  int checkCount = 0;
  int eocCount = 0;

  itp_iso_tx_pacing dut_u (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cycleStart(cycleStart),
    .cycleNumber(cycleNumber), .cycleRollover(cycleRollover), .isoPeriod(isoPeriod),
    .arbWon(arbWon), .arbReq(arbReq), .fifoValid(fifoValid), .fifoHead(fifoHead),
    .fifoPop(fifoPop), .txWord(txWord), .contextPassDone(contextPassDone),
    .skipActive(skipActive), .fifoWrReady(1'b1), .serviceReq(serviceReq),
    .skipNow(skipNow), .eocWrite(eocWrite), .matchCycle(matchCycle),
    .startMatch(startMatch), .cycleNumberMismatch(cycleNumberMismatch),
    .contextStop(contextStop));

  itp_link_model link_u (.clock(clock), .arst_n(arst_n), .fifoPop(fifoPop),
    .fifoValid(fifoValid), .fifoHead(fifoHead), .txWord(txWord));

  // ====
  // helpers
  always @(posedge clock) begin
    if (eocWrite === 1'b1) begin
      eocCount++;
    end
  end

  task automatic finishTest();
    if (nErrors == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finishTest

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // single transfer; no wait-state count assumed, the watchdog ends a hang
  task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, adr};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic pulse(input int k);
    case (k)
      0: cycleStart <= 1'b1;
      1: contextPassDone <= 1'b1;
      2: cycleRollover <= 1'b1;
      default: cycleNumberMismatch <= 1'b1;
    endcase
    tick(1);
    cycleNumberMismatch <= 1'b0;
    cycleStart <= 1'b0;
    contextPassDone <= 1'b0;
    cycleRollover <= 1'b0;
  endtask : pulse

  // ====
  // scenarios
  task automatic t_prime();
    chk("hresp", 1'b0, hresp);
    ahb(1'b0, ITP_OFS_CTRL, ITP_RESET_WORD);
    chk("ctrl reset", ITP_RESET_WORD, rd);
    ahb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h1C, ITP_RESET_WORD);
    chk("unmapped", ITP_RESET_WORD, rd);
    eocCount = 0;
    ahb(1'b1, ITP_OFS_CTRL, 32'h0000_0001);
    tick(8);
    chk("prime tokens", 4'h2, eocCount);
    ahb(1'b0, ITP_OFS_STATUS, ITP_RESET_WORD);
    chk("ahead primed", 4'h2, rd[3:0]);
    expCyc = rd[28:16];
    e1 = (expCyc == ITP_CYC_LAST) ? 13'h0_000 : expCyc + 13'h0_001;
    chk("service idle", 1'b0, serviceReq);
  endtask : t_prime

  task automatic t_sync();
    cycleNumber <= ITP_CYC_LAST;
    tick(1);
    pulse(0);
    tick(3);
    chk("service behind", 1'b1, serviceReq);
    chk("match wrap", 13'h0_000, matchCycle);
    ahb(1'b1, ITP_OFS_START_CYCLE, 32'h0000_0001);
    tick(1);
    chk("start no match", 1'b0, startMatch);
    ahb(1'b1, ITP_OFS_START_CYCLE, ITP_RESET_WORD);
    tick(1);
    chk("start match", 1'b1, startMatch);
    eocCount = 0;
    pulse(1);
    tick(2);
    chk("pass token", 4'h1, eocCount);
    chk("stalled", 1'b0, serviceReq);
    ahb(1'b0, ITP_OFS_STATUS, ITP_RESET_WORD);
    chk("ahead refill", 4'h2, rd[3:0]);
  endtask : t_sync

  task automatic t_packet();
    cycleNumber <= expCyc;
    isoPeriod <= 1'b1;
    arbWon <= 1'b1;
    link_u.push(1'b0, 1'b0, 32'hA5A5_0001);
    link_u.push(1'b0, 1'b1, 32'h5A5A_0002);
    link_u.push(1'b1, 1'b0, 32'h0000_0000);
    tick(1);
    pulse(0);
    tick(12);
    chk("words sent", 4'h2, link_u.sent.size());
    chk("word0", 32'hA5A5_0001, link_u.sent[0].data);
    chk("word1 last", 1'b1, link_u.sent[1].last);
    chk("token taken", 1'b0, fifoValid);
    ahb(1'b0, ITP_OFS_STATUS, ITP_RESET_WORD);
    chk("expected next", e1, rd[28:16]);
  endtask : t_packet

  task automatic t_loss();
    cycleNumber <= e1;
    isoPeriod <= 1'b0;
    link_u.push(1'b0, 1'b1, 32'h0000_0C0C);
    tick(1);
    pulse(0);
    tick(8);
    ahb(1'b0, ITP_OFS_LOSS_COUNT, ITP_RESET_WORD);
    chk("loss count", 4'h1, rd);
    ahb(1'b0, ITP_OFS_STATUS, ITP_RESET_WORD);
    chk("lost pending", 4'h1, rd[11:8]);
    chk("expected kept", e1, rd[28:16]);
    chk("skip now", 1'b1, skipNow);
    skipActive <= 1'b1;
    eocCount = 0;
    pulse(1);
    skipActive <= 1'b0;
    tick(2);
    chk("skip no token", 4'h0, eocCount);
    ahb(1'b0, ITP_OFS_STATUS, ITP_RESET_WORD);
    chk("lost cleared", 4'h0, rd[11:8]);
  endtask : t_loss

  task automatic t_arb();
    isoPeriod <= 1'b1;
    arbWon <= 1'b0;
    pulse(0);
    tick(5);
    chk("arbitrating", 1'b1, arbReq);
    pulse(2);
    tick(2);
    chk("one rollover", 1'b1, arbReq);
    pulse(2);
    tick(3);
    chk("arb given up", 1'b0, arbReq);
    ahb(1'b0, ITP_OFS_LOSS_COUNT, ITP_RESET_WORD);
    chk("loss count arb", 4'h2, rd);
  endtask : t_arb

  task automatic t_underflow();
    arbWon <= 1'b1;
    link_u.push(1'b0, 1'b0, 32'hC3C3_0003);
    pulse(0);
    tick(12);
    link_u.push(1'b0, 1'b1, 32'hC3C3_0004);
    tick(4);
    link_u.push(1'b1, 1'b0, 32'h0000_0000);
    tick(6);
    chk("underflow sent", 4'h4, link_u.sent.size());
    chk("underflow drained", 1'b0, fifoValid);
    ahb(1'b0, ITP_OFS_LOSS_COUNT, ITP_RESET_WORD);
    chk("no loss on last", 4'h2, rd);
    ahb(1'b0, ITP_OFS_STATUS, ITP_RESET_WORD);
    chk("cycle after uf", e1 + 13'h0_001, rd[28:16]);
  endtask : t_underflow

  task automatic t_stop();
    ahb(1'b1, ITP_OFS_CYCLE_DEP, 32'h0000_0005);
    pulse(3);
    tick(1);
    chk("stop flags", 8'h05, contextStop);
    ahb(1'b1, ITP_OFS_STOPPED, 32'h0000_0001);
    ahb(1'b0, ITP_OFS_STOPPED, ITP_RESET_WORD);
    chk("stop cleared", 8'h04, rd);
  endtask : t_stop

  // ====
  // clock, reset, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    #125000;
    nErrors++;
    finishTest();
  end

  initial begin
    {arst_n, hsel, hwrite, cycleStart, cycleRollover, isoPeriod, arbWon} = '0;
    {contextPassDone, skipActive, haddr, hwdata, htrans, cycleNumber, cycleNumberMismatch} = '0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    tick(1);
    t_prime();
    t_sync();
    t_packet();
    t_loss();
    t_arb();
    t_underflow();
    t_stop();
    finishTest();
  end
endmodule : itp_iso_tx_pacing_test
